/* pkg/vsb_defines.vh */
/*
 * Constants of the sync and blank output stage: register offsets,
 * control bit positions, reset values and pipeline counts.
 * Assumes inclusion by bare name from the core files.
 */
`ifndef VSB_DEFINES_VH
`define VSB_DEFINES_VH

// ----------------------------------------
// Register map (word index)
// ----------------------------------------
`define VSB_ADDR_W 9
`define VSB_DATA_W 24
`define VSB_CTRL_ADDR 9'h160
`define VSB_STAT_ADDR 9'h161
`define VSB_CTRL_RST 24'h000000

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define VSB_C_RUN 0
`define VSB_C_ILACE 2
`define VSB_C_CS_PLAIN 3
`define VSB_C_LINE_SYNC 4
`define VSB_C_SYNC_OFF 5
`define VSB_C_SLAVE 6
`define VSB_C_DLY_LO 9
`define VSB_C_DLY_HI 11
`define VSB_C_BLANK_OFF 15
`define VSB_C_BPIN_IN 16
`define VSB_C_BPIN_CDIS 23

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define VSB_S_LOCKED 0
`define VSB_S_RESYNC 1
`define VSB_S_FIELD 2
`define VSB_S_BLANK_IN 3
`define VSB_S_SLAVE 4

// ----------------------------------------
// Pipeline and lock timing, in serial clocks, and sync bundle width
// ----------------------------------------
`define VSB_BASE_STAGES 2
`define VSB_MODE1_EXTRA 4'h1
`define VSB_DLY_DEPTH 9
`define VSB_LOCK_DLY 4'h6
`define VSB_SIG_W 5

`endif

/* core/vsb_dly.v */
/*
 * Selectable delay line for the sync and blank bundle.
 * Assumes sel_i never exceeds the line depth; sel 0 passes straight through.
 */
`timescale 1ns/1ps
`include "vsb_defines.vh"

module vsb_dly (
    input wire mclk_i,                    // Serial clock
    input wire rst_b_i,                   // Sync reset, active low
    input wire [3:0] sel_i,               // Extra stages wanted
    input wire [`VSB_SIG_W-1:0] sig_i,    // Undelayed bundle
    output wire [`VSB_SIG_W-1:0] sig_o    // Delayed bundle
);

    wire [`VSB_SIG_W-1:0] tap [0:`VSB_DLY_DEPTH];

    assign tap[0] = sig_i;

    // ----------------------------------------
    // Shift stages
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `VSB_DLY_DEPTH; g = g + 1) begin : g_stage
            reg [`VSB_SIG_W-1:0] st_q;
            always @(posedge mclk_i) begin
                if (!rst_b_i) begin
                    st_q <= {`VSB_SIG_W{1'b0}};
                end else begin
                    st_q <= tap[g];
                end
            end
            assign tap[g+1] = st_q;
        end
    endgenerate

    assign sig_o = tap[sel_i];

endmodule

/* core/vsb_gen.v */
/*
 * Sync and blank output stage of a video timing generator: DAC sync and
 * blank with programmable delay, master sync pins, slave lock logic and
 * the digital blank pin.
 * Assumes the timing generator supplies active-high sync and blank levels
 * on this clock and a pixel latch strobe from the pixel port.
 */
`timescale 1ns/1ps
`include "vsb_defines.vh"


module vsb_gen (
    input wire mclk_i,                        // Serial dot clock
    input wire rst_b_i,                       // Sync reset, active low
    input wire [`VSB_ADDR_W-1:0] reg_addr_i,  // Register index
    input wire [`VSB_DATA_W-1:0] reg_wdata_i, // Write data
    input wire reg_wr_i,                      // Write strobe
    input wire reg_rd_i,                      // Read strobe
    output reg [`VSB_DATA_W-1:0] reg_rdata_o, // Read data, cycle after strobe
    input wire vtg_csync_ser_i,               // Serrated composite sync, high active
    input wire vtg_csync_plain_i,             // Plain composite sync, high active
    input wire vtg_hsync_i,                   // Line sync, high active
    input wire vtg_vsync_i,                   // Frame sync, high active
    input wire vtg_blank_i,                   // Blank excluding even half line
    input wire vtg_even_half_i,               // First half of line 0, even field
    input wire vtg_field_i,                   // Current field, 1 even
    input wire mode_mux_i,                    // Multiplexed pixel mode
    input wire pix_latch_i,                   // Pixel input latch strobe
    output reg vtg_run_o,                     // Generator enable
    output reg vtg_restart_o,                 // Restart pulse, on run start and on slave lock
    output reg dac_sync_o,                    // Composite sync to DACs
    output reg dac_blank_o,                   // Composite blank to DACs
    input wire frame_sync_pin_i,              // Frame sync pin level
    output reg frame_sync_pin_o,              // Frame sync drive, low active
    output reg frame_sync_pin_oe_b_o,         // Low while driving
    input wire line_or_composite_sync_pin_i,  // Line/composite pin level
    output reg line_or_composite_sync_pin_o,  // Line/composite drive, low active
    output reg line_or_composite_sync_pin_oe_b_o, // Low while driving
    input wire digital_blank_pin_i,           // Blank pin level
    output reg digital_blank_pin_o,           // Blank or clock disable drive
    output reg digital_blank_pin_oe_b_o       // Low while driving
);

    reg [`VSB_DATA_W-1:0] ctrl_q;
    reg run_prev_q;
    reg [`VSB_SIG_W-1:0] base0_q;
    reg [`VSB_SIG_W-1:0] base1_q;
    reg [`VSB_SIG_W-1:0] base2_q;
    reg vs_m_q;
    reg vs_s_q;
    reg vs_prev_q;
    reg hs_m_q;
    reg hs_s_q;
    reg [3:0] lock_cnt_q;
    reg lock_busy_q;
    reg locked_q;
    reg resync_q;
    reg ext_field_q;
    reg blank_in_q;

    wire slave = ctrl_q[`VSB_C_SLAVE];
    wire ilace = ctrl_q[`VSB_C_ILACE];
    wire [3:0] dly_sel;
    wire [`VSB_SIG_W-1:0] raw;
    wire [`VSB_SIG_W-1:0] dly;
    wire vs_fall;
    wire comp_blank;
    wire line_pin;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ctrl_q <= `VSB_CTRL_RST;
            reg_rdata_o <= 24'h000000;
        end else begin
            if (reg_wr_i && reg_addr_i == `VSB_CTRL_ADDR) begin
                ctrl_q <= reg_wdata_i;
            end
            if (reg_rd_i && reg_addr_i == `VSB_CTRL_ADDR) begin
                reg_rdata_o <= ctrl_q;
            end else if (reg_rd_i && reg_addr_i == `VSB_STAT_ADDR) begin
                reg_rdata_o <= {19'h00000, slave, blank_in_q, ext_field_q,
                    resync_q, locked_q};
            end else begin
                reg_rdata_o <= 24'h000000;
            end
        end
    end

    // ----------------------------------------
    // Sync and blank pipeline
    // ----------------------------------------
    // In interlace the even half line is blanked at the DACs and at the delayed blank pin, not in clock disable
    assign comp_blank = vtg_blank_i | (ilace & vtg_even_half_i);
    assign raw = {vtg_vsync_i, vtg_hsync_i, vtg_csync_plain_i, vtg_csync_ser_i, comp_blank};

    // Fixed stages plus the mode-dependent one keep sync aligned with data
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            base0_q <= {`VSB_SIG_W{1'b0}};
            base1_q <= {`VSB_SIG_W{1'b0}};
            base2_q <= {`VSB_SIG_W{1'b0}};
        end else begin
            base0_q <= raw;
            base1_q <= base0_q;
            base2_q <= base1_q;
        end
    end

    // Multiplexed mode needs one more stage; programmable part adds 0..7
    assign dly_sel = (mode_mux_i ? `VSB_MODE1_EXTRA : 4'h0)
        + {1'b0, ctrl_q[`VSB_C_DLY_HI:`VSB_C_DLY_LO]};

    vsb_dly u_dly (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .sel_i(dly_sel),
        .sig_i(base2_q),
        .sig_o(dly)
    );

    // ----------------------------------------
    // DAC and sync pin outputs
    // ----------------------------------------
    assign line_pin = ctrl_q[`VSB_C_LINE_SYNC] ? dly[3] :
        (ctrl_q[`VSB_C_CS_PLAIN] ? dly[2] : dly[1]);

    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            dac_sync_o <= 1'b0;
            dac_blank_o <= 1'b0;
            frame_sync_pin_o <= 1'b1;
            line_or_composite_sync_pin_o <= 1'b1;
            frame_sync_pin_oe_b_o <= 1'b1;
            line_or_composite_sync_pin_oe_b_o <= 1'b1;
        end else begin
            dac_sync_o <= dly[1] & ~ctrl_q[`VSB_C_SYNC_OFF];
            dac_blank_o <= (dly[0] | blank_in_q) & ~ctrl_q[`VSB_C_BLANK_OFF];
            frame_sync_pin_o <= ~dly[4];
            line_or_composite_sync_pin_o <= ~line_pin;
            frame_sync_pin_oe_b_o <= slave;
            line_or_composite_sync_pin_oe_b_o <= slave;
        end
    end

    // ----------------------------------------
    // Digital blank pin
    // ----------------------------------------
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            blank_in_q <= 1'b0;
            digital_blank_pin_o <= 1'b0;
            digital_blank_pin_oe_b_o <= 1'b1;
        end else begin
            digital_blank_pin_oe_b_o <= ctrl_q[`VSB_C_BPIN_IN];
            if (!ctrl_q[`VSB_C_BPIN_IN]) begin
                blank_in_q <= 1'b0;
            end else if (pix_latch_i) begin
                blank_in_q <= digital_blank_pin_i;
            end
            if (ctrl_q[`VSB_C_BPIN_CDIS]) begin
                // Undelayed, and idle over the even half line
                digital_blank_pin_o <= vtg_blank_i;
            end else begin
                digital_blank_pin_o <= dly[0];
            end
        end
    end

    // ----------------------------------------
    // Slave synchroniser and lock
    // ----------------------------------------
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            vs_m_q <= 1'b1;
            vs_s_q <= 1'b1;
            vs_prev_q <= 1'b1;
            hs_m_q <= 1'b1;
            hs_s_q <= 1'b1;
        end else begin
            vs_m_q <= frame_sync_pin_i;
            vs_s_q <= vs_m_q;
            vs_prev_q <= vs_s_q;
            hs_m_q <= line_or_composite_sync_pin_i;
            hs_s_q <= hs_m_q;
        end
    end

    assign vs_fall = slave & vs_prev_q & ~vs_s_q;

    // Restart follows detection by a constant count
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            run_prev_q <= 1'b0;
            vtg_run_o <= 1'b0;
            vtg_restart_o <= 1'b0;
            lock_cnt_q <= 4'h0;
            lock_busy_q <= 1'b0;
            locked_q <= 1'b0;
            resync_q <= 1'b0;
            ext_field_q <= 1'b0;
        end else begin
            run_prev_q <= ctrl_q[`VSB_C_RUN];
            vtg_run_o <= ctrl_q[`VSB_C_RUN];
            vtg_restart_o <= 1'b0;
            if (ctrl_q[`VSB_C_RUN] && !run_prev_q) begin
                vtg_restart_o <= 1'b1;
            end
            if (!slave || !ctrl_q[`VSB_C_RUN]) begin
                locked_q <= 1'b0;
                resync_q <= 1'b0;
                lock_busy_q <= 1'b0;
            end else if (lock_busy_q) begin
                if (lock_cnt_q == `VSB_LOCK_DLY) begin
                    vtg_restart_o <= 1'b1;
                    lock_busy_q <= 1'b0;
                    locked_q <= 1'b1;
                    resync_q <= 1'b0;
                end else begin
                    lock_cnt_q <= lock_cnt_q + 4'h1;
                end
            end else if (vs_fall) begin
                // Line sync low at the frame edge marks the even field
                ext_field_q <= ~hs_s_q;
                if (!locked_q || resync_q) begin
                    lock_busy_q <= 1'b1;
                    lock_cnt_q <= 4'h1;
                end else if (ilace && (~hs_s_q != vtg_field_i)) begin
                    resync_q <= 1'b1;
                end
            end
        end
    end

endmodule

/* dv/vsb_gen_checker.sv */
/* Port checker for the sync and blank stage.
   Assumes bind to vsb_gen; tracks the control word from bus writes. */
`timescale 1ns/1ps
`include "vsb_defines.vh"
module vsb_gen_checker (
    input wire mclk_i, // Clock
    input wire rst_b_i, // Reset
    input wire [`VSB_ADDR_W-1:0] reg_addr_i, // Index
    input wire [`VSB_DATA_W-1:0] reg_wdata_i, // Data
    input wire reg_wr_i, // Write
    input wire vtg_csync_ser_i, // Serrated
    input wire vtg_csync_plain_i, // Plain
    input wire vtg_hsync_i, // Line
    input wire vtg_vsync_i, // Frame
    input wire vtg_blank_i, // Blank
    input wire vtg_even_half_i, // Half line
    input wire mode_mux_i, // Mux mode
    input wire vtg_restart_o, // Restart
    input wire dac_sync_o, // DAC sync
    input wire dac_blank_o, // DAC blank
    input wire frame_sync_pin_o, // Frame pin
    input wire frame_sync_pin_oe_b_o, // Frame oe
    input wire line_or_composite_sync_pin_o, // Line pin
    input wire line_or_composite_sync_pin_oe_b_o, // Line oe
    input wire digital_blank_pin_o, // Blank pin
    input wire digital_blank_pin_oe_b_o // Blank oe
);
default clocking @(posedge mclk_i); endclocking
default disable iff (!rst_b_i);
// ----------------------------------------
// Control copy and settle counter
// ----------------------------------------
reg [23:0] c_q;
reg [3:0] q_q;
wire w = reg_wr_i && reg_addr_i == `VSB_CTRL_ADDR;
wire ok = q_q > 4'h8 && c_q[11:9] == 3'h0;
always @(posedge mclk_i) begin
    c_q <= !rst_b_i ? 24'h0 : w ? reg_wdata_i : c_q;
    q_q <= (!rst_b_i || w || mode_mux_i != $past(mode_mux_i)) ? 4'h0 : q_q + {3'h0, q_q != 4'hF};
end
a_dac_sync_path: assert property (ok && !mode_mux_i |->
    dac_sync_o == ($past(vtg_csync_ser_i, 4) & ~c_q[5])) else $error("dac sync wrong");
a_mux_extra_stage: assert property (ok && mode_mux_i |->
    dac_sync_o == ($past(vtg_csync_ser_i, 5) & ~c_q[5])) else $error("mux lag wrong");
a_dac_blank_path: assert property (ok && !mode_mux_i && !c_q[16] |-> dac_blank_o ==
    (($past(vtg_blank_i, 4) | c_q[2] & $past(vtg_even_half_i, 4)) & ~c_q[15]))
    else $error("dac blank wrong");
a_frame_pin_plain: assert property (ok && !mode_mux_i && !c_q[6] |->
    frame_sync_pin_o == !$past(vtg_vsync_i, 4)) else $error("frame pin wrong");
a_line_pin_style: assert property (ok && !mode_mux_i && !c_q[6] |->
    line_or_composite_sync_pin_o != (c_q[4] ? $past(vtg_hsync_i, 4) : c_q[3] ?
    $past(vtg_csync_plain_i, 4) : $past(vtg_csync_ser_i, 4))) else $error("line pin wrong");
a_sync_pin_dir: assert property (q_q > 4'h1 |-> frame_sync_pin_oe_b_o == c_q[6] &&
    line_or_composite_sync_pin_oe_b_o == c_q[6]) else $error("sync pin dir wrong");
a_blank_pin_dir: assert property (q_q > 4'h1 |->
    digital_blank_pin_oe_b_o == c_q[16]) else $error("blank pin dir wrong");
a_clk_dis_undelayed: assert property (q_q > 4'h8 && !c_q[16] && c_q[23] |->
    digital_blank_pin_o == $past(vtg_blank_i)) else $error("clock disable wrong");
a_run_restart: assert property (w && reg_wdata_i[0] && !c_q[0] |->
    ##[1:2] vtg_restart_o) else $error("no restart");
endmodule
bind vsb_gen vsb_gen_checker i_vsb_gen_checker (.*);

/* dv/vsb_sync_src.sv */
/* External sync source and pin resolution.
   Assumes pull-ups on the sync pins; drives only pins the device releases. */
`timescale 1ns/1ps
module vsb_sync_src (
    input wire fs_i, // Frame pulse wanted
    input wire ls_i, // Line pulse wanted
    input wire blk_i, // Blank level applied
    input wire f_i, // Device frame drive
    input wire f_oe_b_i, // Device frame oe
    input wire l_i, // Device line drive
    input wire l_oe_b_i, // Device line oe
    input wire b_i, // Device blank drive
    input wire b_oe_b_i, // Device blank oe
    output wire frame_w_o, // Frame wire
    output wire line_w_o, // Line wire
    output wire blank_w_o // Blank wire
);
// Skewed 3 ns off the clock edge, so the source changes at a fixed phase between edges
assign #3 frame_w_o = !f_oe_b_i ? f_i : !fs_i;
assign #3 line_w_o = !l_oe_b_i ? l_i : !ls_i;
assign #3 blank_w_o = !b_oe_b_i ? b_i : blk_i;
endmodule

/* dv/vsb_gen_test.sv */
/* Self-checking bench for the sync and blank stage.
   Assumes the checker is bound and vsb_sync_src models the far side. */
`timescale 1ns/1ps
`include "vsb_defines.vh"
module vsb_gen_test;
reg mclk = 0, rst_b = 0, wr_s = 0, rd_s = 0, mux = 0, pl = 0, fld = 0;
reg fs = 0, ls = 0, blk = 0;
reg [8:0] addr = 9'h0;
reg [23:0] wd = 24'h0, d, n;
reg [5:0] vt = 6'h0;
wire [23:0] rdata;
wire run, rs, dsy, dbl, fo, foe, lo, loe, bo, boe, fw, lw, bw;
integer n_errors = 0, n_tests = 0, k, j;
always #5 mclk = ~mclk;
vsb_gen i_vsb_gen (.mclk_i(mclk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .vtg_csync_ser_i(vt[0]),
    .vtg_csync_plain_i(vt[1]), .vtg_hsync_i(vt[2]), .vtg_vsync_i(vt[3]),
    .vtg_blank_i(vt[4]), .vtg_even_half_i(vt[5]), .vtg_field_i(fld), .mode_mux_i(mux),
    .pix_latch_i(pl), .vtg_run_o(run), .vtg_restart_o(rs), .dac_sync_o(dsy),
    .dac_blank_o(dbl), .frame_sync_pin_i(fw), .frame_sync_pin_o(fo),
    .frame_sync_pin_oe_b_o(foe), .line_or_composite_sync_pin_i(lw),
    .line_or_composite_sync_pin_o(lo), .line_or_composite_sync_pin_oe_b_o(loe),
    .digital_blank_pin_i(bw), .digital_blank_pin_o(bo), .digital_blank_pin_oe_b_o(boe));
vsb_sync_src i_vsb_sync_src (.fs_i(fs), .ls_i(ls), .blk_i(blk), .f_i(fo), .f_oe_b_i(foe),
    .l_i(lo), .l_oe_b_i(loe), .b_i(bo), .b_oe_b_i(boe), .frame_w_o(fw), .line_w_o(lw),
    .blank_w_o(bw));
// ----------------------------------------
// Bus, compare and timing tasks
// ----------------------------------------
task wr(input [8:0] a, input [23:0] v);
    begin
        @(posedge mclk);
        addr <= a; wd <= v; wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
    end
endtask
task rd(input [8:0] a);
    begin
        @(posedge mclk);
        addr <= a; rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1 d = rdata;
    end
endtask
task chk(input [8*12-1:0] nm, input [23:0] e, input [23:0] g);
    begin
        n_tests = n_tests + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
        end
    end
endtask
// Pulses inputs m once; n = edges until output o first goes active, 0 if never
task lat(input [5:0] m, input integer o);
    integer i;
    reg [4:0] s;
    begin
        n = 0;
        @(posedge mclk);
        vt <= m;
        for (i = 1; i < 16; i = i + 1) begin
            @(posedge mclk);
            vt <= 6'h0;
            #1 s = {dsy, dbl, !fo, !lo, bo};
            if (s[o] === 1'b1 && n == 0) n = i;
        end
    end
endtask
task wt;
    begin
        n = 0;
        while (rs !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1 n = n + 1;
        end
        if (n == 40) begin
            n_errors = n_errors + 1;
            complete_run;
        end
    end
endtask
task complete_run;
    begin
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    end
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    wr(9'h1B0, 24'hFFFFFF);
    rd(`VSB_CTRL_ADDR); chk("ctrl", 24'h0, d);
    rd(9'h1B0); chk("unmapped", 24'h0, d);
    for (k = 0; k < 16; k = k + 1) begin
        mux <= k[3];
        wr(`VSB_CTRL_ADDR, {12'h0, k[2:0], 9'h0});
        lat(6'h01, 4); chk("sync lag", 24'd4 + k[3] + k[2:0], n);
    end
    mux <= 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
        wr(`VSB_CTRL_ADDR, {19'h0, k[1:0], 3'h0});
        lat(6'h08, 2); chk("frame pin", 24'd4, n);
        for (j = 0; j < 3; j = j + 1) begin
            lat(6'h01 << j, 1);
            chk("line pin", (k[1] ? 2 : k[0]) == j ? 24'd4 : 24'd0, n);
        end
    end
    wr(`VSB_CTRL_ADDR, 24'h008020);
    lat(6'h01, 4); chk("sync off", 24'd0, n);
    lat(6'h10, 3); chk("blank off", 24'd0, n);
    wr(`VSB_CTRL_ADDR, 24'h0);
    lat(6'h10, 3); chk("dac blank", 24'd4, n);
    lat(6'h10, 0); chk("blank pin", 24'd4, n);
    wr(`VSB_CTRL_ADDR, 24'h800004);
    lat(6'h10, 0); chk("clk dis", 24'd1, n);
    lat(6'h20, 0); chk("half dis", 24'd0, n);
    lat(6'h20, 3); chk("half blank", 24'd4, n);
    wr(`VSB_CTRL_ADDR, 24'h010040);
    blk <= 1'b1;
    @(posedge mclk);
    pl <= 1'b1;
    @(posedge mclk);
    pl <= 1'b0;
    #1 chk("pins off", 24'h7, {foe, loe, boe});
    rd(`VSB_STAT_ADDR); chk("blank in", 24'h18, d & 24'h18);
    wr(`VSB_CTRL_ADDR, 24'h000041);
    repeat (4) @(posedge mclk);
    fs <= 1'b1;
    wt; chk("lock lag", 24'd9, n);
    rd(`VSB_STAT_ADDR); chk("locked", 24'h1, d & 24'h1);
    fs <= 1'b0;
    wr(`VSB_CTRL_ADDR, 24'h000045);
    repeat (20) @(posedge mclk);
    fs <= 1'b1; ls <= 1'b1;
    repeat (8) @(posedge mclk);
    fs <= 1'b0; ls <= 1'b0;
    rd(`VSB_STAT_ADDR); chk("field err", 24'h6, d & 24'h6);
    fld <= 1'b1;
    repeat (20) @(posedge mclk);
    fs <= 1'b1; ls <= 1'b1;
    wt; chk("relock", 24'd9, n);
    complete_run;
end
endmodule
